/* design/backlight_pkg.sv */
package backlight_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_BRIGHTNESS = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h01;
	localparam logic [7:0] OFF_FAULT = 8'h02;
	localparam logic [7:0] OFF_IDENTITY = 8'h03;
	localparam logic [7:0] OFF_DIRECT = 8'h04;
	localparam logic [7:0] OFF_TEMP_HIGH = 8'h05;
	localparam logic [7:0] OFF_TEMP_LOW = 8'h06;
	localparam logic [7:0] OFF_NVM = 8'h72;

	// ----------------------------------------
	// field positions and encodings
	// ----------------------------------------
	localparam int BIT_BACKLIGHT_ON = 0;
	localparam int BIT_SOURCE_LO = 1;
	localparam int BIT_SOURCE_HI = 2;
	localparam int BIT_OPEN_LED = 7;
	localparam int BIT_NVM_IDLE = 7;
	localparam int NVM_CMD_WIDTH = 3;
	localparam int TEMP_WIDTH = 11;
	localparam logic [1:0] SRC_PIN_DUTY_A = 2'h0;
	localparam logic [1:0] SRC_PIN_DUTY_B = 2'h1;
	localparam logic [1:0] SRC_REGISTER = 2'h2;
	localparam logic [1:0] SRC_PIN_DIRECT = 2'h3;

	// ----------------------------------------
	// reset values and serial address
	// ----------------------------------------
	localparam logic [7:0] RST_BRIGHTNESS = 8'h00;
	localparam logic [2:0] RST_CONFIG = 3'h0;
	localparam logic [7:0] RST_FAULT = 8'h00;
	localparam logic [7:0] RST_DIRECT = 8'h00;
	localparam logic [TEMP_WIDTH-1:0] RST_TEMP = 11'h000;
	localparam logic [6:0] SLAVE_ADDR = 7'h2C;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------
	// serial engine states, gray along the write path; dev ack to read flips two bits
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DEV = 3'h1,
		ST_DEV_ACK = 3'h3,
		ST_REG = 3'h2,
		ST_REG_ACK = 3'h6,
		ST_WR = 3'h7,
		ST_RD = 3'h5,
		ST_RD_ACK = 3'h4
	} serial_state_t;

endpackage

/* design/pwm_generator.sv */
`timescale 1ns/100ps
// ----------------------------------------
// linear pwm: duty = level / (2**WIDTH - 1)
// ----------------------------------------
module pwm_generator #(
	parameter int WIDTH = 8
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_level,
	output logic o_pwm,
	output logic o_period_end
);
	localparam logic [WIDTH-1:0] LAST = WIDTH'(2 ** WIDTH - 2);

	// the counter needs three states at least, and the level port stays bounded
	if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
		$error("pwm_generator: WIDTH out of range");
	end

	logic [WIDTH-1:0] count_q, count_d;
	logic pwm_q, pwm_d;
	logic end_q, end_d;

	// full scale level stays high all period, zero stays low
	always_comb begin
		count_d = (count_q == LAST) ? '0 : count_q + 1'b1;
		pwm_d = i_level > count_q;
		end_d = count_q == LAST;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_q <= '0;
			pwm_q <= 1'b0;
			end_q <= 1'b0;
		end else begin
			count_q <= count_d;
			pwm_q <= pwm_d;
			end_q <= end_d;
		end
	end

	assign o_pwm = pwm_q;
	assign o_period_end = end_q;

	period_len_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_period_end |=> !o_period_end [*2]) else $error("period end too close");
endmodule

/* design/backlight_control_register_bank.sv */
`timescale 1ns/100ps
module backlight_control_register_bank #(
	parameter logic [7:0] IDENTITY = 8'hA5 // arbitrary value
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_chip_enable,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_pwm_in,
	input wire logic [7:0] i_fault_events,
	input wire logic [backlight_pkg::TEMP_WIDTH-1:0] i_temperature,
	input wire logic i_nvm_idle,
	output logic o_pwm_out,
	output logic o_backlight_on,
	output logic o_fault_out,
	output logic o_fault_oe,
	output logic [7:0] o_direct_drive,
	output logic [backlight_pkg::NVM_CMD_WIDTH-1:0] o_nvm_cmd
);
	// ----------------------------------------
	// pin synchronisers: scl, sda, pwm, enable
	// ----------------------------------------
	localparam int NPIN = 4;
	localparam logic [NPIN-1:0] PIN_RST = 4'h3;
	logic [NPIN-1:0] pin_raw, pin_f_q, pin_p_q;
	assign pin_raw = {i_chip_enable, i_pwm_in, i_sda, i_scl};

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_sync
			logic s1_q, s2_q, s3_q;
			// a change counts only once stages two and three agree
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					s1_q <= PIN_RST[g];
					s2_q <= PIN_RST[g];
					s3_q <= PIN_RST[g];
					pin_f_q[g] <= PIN_RST[g];
					pin_p_q[g] <= PIN_RST[g];
				end else begin
					s1_q <= pin_raw[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					pin_f_q[g] <= (s2_q == s3_q) ? s3_q : pin_f_q[g];
					pin_p_q[g] <= pin_f_q[g];
				end
			end
		end
	endgenerate

	logic scl_f, sda_f, pwm_f, en_f, scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_f = pin_f_q[0];
	assign sda_f = pin_f_q[1];
	assign pwm_f = pin_f_q[2];
	assign en_f = pin_f_q[3];
	assign scl_rise = scl_f && !pin_p_q[0];
	assign scl_fall = !scl_f && pin_p_q[0];
	assign start_ev = scl_f && pin_p_q[0] && pin_p_q[1] && !sda_f;
	assign stop_ev = scl_f && pin_p_q[0] && !pin_p_q[1] && sda_f;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0] bright_q, bright_d, fault_q, fault_d, direct_q, direct_d;
	logic [2:0] cfg_q, cfg_d;
	logic [backlight_pkg::TEMP_WIDTH-1:0] temp_q;
	logic [backlight_pkg::NVM_CMD_WIDTH-1:0] nvm_q, nvm_d;
	logic fault_oe_q;
	logic [7:0] rd_data;
	logic wr_stb, fault_clr;

	// ----------------------------------------
	// serial engine state
	// ----------------------------------------
	backlight_pkg::serial_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
	logic rw_q, rw_d, drv_q, drv_d;

	// unmapped offsets fall to zero, unused bits read zero
	always_comb begin
		unique case (ptr_q)
			backlight_pkg::OFF_BRIGHTNESS: rd_data = bright_q;
			backlight_pkg::OFF_CONFIG: rd_data = {5'h00, cfg_q};
			backlight_pkg::OFF_FAULT: rd_data = fault_q;
			backlight_pkg::OFF_IDENTITY: rd_data = IDENTITY;
			backlight_pkg::OFF_DIRECT: rd_data = direct_q;
			backlight_pkg::OFF_TEMP_HIGH: rd_data = temp_q[10:3];
			backlight_pkg::OFF_TEMP_LOW: rd_data = {temp_q[2:0], 5'h00};
			backlight_pkg::OFF_NVM: rd_data = {i_nvm_idle, 7'h00};
			default: rd_data = 8'h00;
		endcase
	end

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		drv_d = drv_q;
		wr_stb = 1'b0;
		fault_clr = 1'b0;
		if (start_ev) begin
			st_d = backlight_pkg::ST_DEV;
			cnt_d = 4'h0;
			drv_d = 1'b0;
		end else if (stop_ev) begin
			st_d = backlight_pkg::ST_IDLE;
			drv_d = 1'b0;
		end else begin
			unique case (st_q)
				backlight_pkg::ST_IDLE: begin
				end
				backlight_pkg::ST_DEV: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_f};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == backlight_pkg::BITS_PER_BYTE) begin
						if (sh_q[7:1] == backlight_pkg::SLAVE_ADDR) begin
							drv_d = 1'b1;
							rw_d = sh_q[0];
							st_d = backlight_pkg::ST_DEV_ACK;
						end else begin
							st_d = backlight_pkg::ST_IDLE;
						end
					end
				end
				backlight_pkg::ST_REG, backlight_pkg::ST_WR: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_f};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == backlight_pkg::BITS_PER_BYTE) begin
						drv_d = 1'b1;
						st_d = backlight_pkg::ST_REG_ACK;
						if (st_q == backlight_pkg::ST_REG) begin
							ptr_d = sh_q;
						end else begin
							wr_stb = 1'b1;
							ptr_d = ptr_q + 8'h01;
						end
					end
				end
				backlight_pkg::ST_REG_ACK: begin
					if (scl_fall) begin
						drv_d = 1'b0;
						cnt_d = 4'h0;
						st_d = backlight_pkg::ST_WR;
					end
				end
				backlight_pkg::ST_DEV_ACK, backlight_pkg::ST_RD_ACK: begin
					if (scl_rise && st_q == backlight_pkg::ST_RD_ACK) begin
						if (sda_f) begin
							st_d = backlight_pkg::ST_IDLE;
						end else begin
							ptr_d = ptr_q + 8'h01;
						end
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (rw_q) begin
							// the fault byte is cleared once it is committed to the wire
							tx_d = {rd_data[6:0], 1'b0};
							drv_d = !rd_data[7];
							fault_clr = ptr_q == backlight_pkg::OFF_FAULT;
							st_d = backlight_pkg::ST_RD;
						end else begin
							drv_d = 1'b0;
							st_d = backlight_pkg::ST_REG;
						end
					end
				end
				backlight_pkg::ST_RD: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == backlight_pkg::BITS_PER_BYTE) begin
							drv_d = 1'b0;
							st_d = backlight_pkg::ST_RD_ACK;
						end else begin
							drv_d = !tx_q[7];
							tx_d = {tx_q[6:0], 1'b0};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= backlight_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			drv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			drv_q <= drv_d;
		end
	end

	// ----------------------------------------
	// register writes and fault latching
	// ----------------------------------------
	always_comb begin
		bright_d = bright_q;
		cfg_d = cfg_q;
		direct_d = direct_q;
		nvm_d = '0;
		if (!en_f) begin
			bright_d = backlight_pkg::RST_BRIGHTNESS;
			cfg_d = backlight_pkg::RST_CONFIG;
			direct_d = backlight_pkg::RST_DIRECT;
		end else if (wr_stb) begin
			unique case (ptr_q)
				backlight_pkg::OFF_BRIGHTNESS: bright_d = sh_q;
				backlight_pkg::OFF_CONFIG: cfg_d = sh_q[2:0];
				backlight_pkg::OFF_DIRECT: direct_d = sh_q;
				backlight_pkg::OFF_NVM: nvm_d = sh_q[2:0];
				default: ;
			endcase
		end
		// a new event wins over a clear in the same cycle
		fault_d = ((en_f && !fault_clr) ? fault_q : backlight_pkg::RST_FAULT) | i_fault_events;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bright_q <= backlight_pkg::RST_BRIGHTNESS;
			cfg_q <= backlight_pkg::RST_CONFIG;
			fault_q <= backlight_pkg::RST_FAULT;
			direct_q <= backlight_pkg::RST_DIRECT;
			temp_q <= backlight_pkg::RST_TEMP;
			nvm_q <= '0;
			fault_oe_q <= 1'b0;
		end else begin
			bright_q <= bright_d;
			cfg_q <= cfg_d;
			fault_q <= fault_d;
			direct_q <= direct_d;
			temp_q <= i_temperature;
			nvm_q <= nvm_d;
			fault_oe_q <= fault_d != 8'h00;
		end
	end

	// ----------------------------------------
	// brightness source and pwm output
	// ----------------------------------------
	logic [1:0] src;
	logic [7:0] level, hi_q, hi_d, meas_q, meas_d;
	logic gen_pwm, period_end, pwm_q, pwm_d, on_q, on_d;
	assign src = cfg_q[backlight_pkg::BIT_SOURCE_HI:backlight_pkg::BIT_SOURCE_LO];
	assign level = (src == backlight_pkg::SRC_REGISTER) ? bright_q : meas_q;

	pwm_generator #(.WIDTH(8)) u_pwm (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_level(level),
		.o_pwm(gen_pwm),
		.o_period_end(period_end)
	);

	// pin duty is sampled over one output period, so it lags by a period
	always_comb begin
		hi_d = period_end ? 8'h00 : hi_q + {7'h00, pwm_f};
		meas_d = period_end ? hi_q : meas_q;
		unique case (src)
			backlight_pkg::SRC_REGISTER: on_d = cfg_q[backlight_pkg::BIT_BACKLIGHT_ON];
			backlight_pkg::SRC_PIN_DIRECT: on_d = pwm_f;
			default: on_d = meas_q != 8'h00;
		endcase
		pwm_d = (src == backlight_pkg::SRC_PIN_DIRECT) ? pwm_f : (gen_pwm && on_d);
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hi_q <= 8'h00;
			meas_q <= 8'h00;
			pwm_q <= 1'b0;
			on_q <= 1'b0;
		end else begin
			hi_q <= hi_d;
			meas_q <= meas_d;
			pwm_q <= pwm_d;
			on_q <= on_d;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = drv_q;
	assign o_fault_out = 1'b0;
	assign o_fault_oe = fault_oe_q;
	assign o_pwm_out = pwm_q;
	assign o_backlight_on = on_q;
	assign o_direct_drive = direct_q;
	assign o_nvm_cmd = nvm_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	bright_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_stb && en_f && ptr_q == 8'h00 |=> bright_q == $past(sh_q))
		else $error("brightness write lost");
	register_mode_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		cfg_q[2:1] == 2'h2 |=> o_backlight_on == $past(cfg_q[0]))
		else $error("register mode enable wrong");
	direct_mode_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		cfg_q[2:1] == 2'h3 ##1 cfg_q[2:1] == 2'h3 |=> o_pwm_out == $past(pwm_f) && o_backlight_on == $past(pwm_f))
		else $error("pin passthrough wrong");
	enable_low_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!en_f && i_fault_events == 8'h00 |=> bright_q == 8'h00 && cfg_q == 3'h0 && fault_q == 8'h00)
		else $error("enable low did not clear");
	open_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_fault_events[7] |=> fault_q[7]) else $error("open flag not set");
	fault_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		fault_q[7] && en_f && !fault_clr |=> fault_q[7]) else $error("fault dropped");
	fault_pin_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		fault_q != 8'h00 |-> o_fault_oe) else $error("fault pin released");
	addr_incr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_stb |=> ptr_q == $past(ptr_q) + 8'h01) else $error("address not advanced");
	unmapped_wr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_stb && en_f && ptr_q > 8'h06 |=> $stable(bright_q) && $stable(cfg_q) && $stable(direct_q))
		else $error("unmapped write had effect");
endmodule

/* dv/serial_host.sv */
`timescale 1ns/100ps
// ----------------------------------------
// serial host and external pwm source
// ----------------------------------------
module serial_host (
	input wire logic i_clock,
	input wire logic i_sda_oe,
	output logic o_scl,
	output logic o_sda,
	output logic o_pwm
);
	logic pull_q = 1'b0;
	// open drain with pull-up: a released line reads high
	assign o_sda = ~(pull_q | i_sda_oe);
	initial begin
		o_scl = 1'b1;
		o_pwm = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task automatic start();
		pull_q <= 1'b1;
		hw(10);
		o_scl <= 1'b0;
		hw(10);
	endtask
	// sda moves a few clocks after scl falls so the synced pair never looks like start or stop
	task automatic rstart();
		hw(4);
		pull_q <= 1'b0;
		hw(8);
		o_scl <= 1'b1;
		hw(10);
		start();
	endtask
	task automatic stop();
		hw(4);
		pull_q <= 1'b1;
		hw(8);
		o_scl <= 1'b1;
		hw(10);
		pull_q <= 1'b0;
		hw(10);
	endtask
	task automatic pulse(input logic low, output logic seen);
		hw(4);
		pull_q <= low;
		hw(8);
		o_scl <= 1'b1;
		hw(5);
		seen = o_sda;
		hw(5);
		o_scl <= 1'b0;
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(~b[i], s);
		end
		pulse(1'b0, s);
		ack = ~s;
	endtask
	task automatic get(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b0, s);
			b[i] = s;
		end
		pulse(ack, s);
	endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) \
	begin \
		n_checks++; \
		if ((g) !== (e)) begin \
			$display("BAD %s exp %h got %h", nm, e, g); \
			err_total++; \
		end \
	end
module tb;
	localparam logic [7:0] ID_VAL = 8'h3C; // arbitrary value
	logic clock, rst_n, chip_enable, scl, sda, sda_out, sda_oe, pwm_pin, nvm_idle;
	logic pwm_out, backlight_on, fault_out, fault_oe;
	logic [7:0] fault_events, direct_drive;
	logic [10:0] temperature;
	logic [2:0] nvm_cmd;
	int err_total = 0;
	int n_checks = 0;
	logic [2:0] nvm_seen = 3'h0;
	serial_host i_host (.i_clock(clock), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda),
		.o_pwm(pwm_pin));
	backlight_control_register_bank #(.IDENTITY(ID_VAL)) i_dut (.i_clock(clock),
		.i_rst_n(rst_n), .i_chip_enable(chip_enable), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_pwm_in(pwm_pin),
		.i_fault_events(fault_events), .i_temperature(temperature), .i_nvm_idle(nvm_idle),
		.o_pwm_out(pwm_out), .o_backlight_on(backlight_on), .o_fault_out(fault_out),
		.o_fault_oe(fault_oe), .o_direct_drive(direct_drive), .o_nvm_cmd(nvm_cmd));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// command pulses last one clock, so the bench keeps a sticky copy
	always @(posedge clock) begin
		if (rst_n) begin
			nvm_seen <= nvm_seen | nvm_cmd;
		end
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
		logic k;
		i_host.start();
		i_host.put(8'h58, k);
		i_host.put(ptr, k);
		foreach (d[i]) begin
			i_host.put(d[i], k);
			`CHK("data ack", 1'b1, k)
		end
		i_host.stop();
	endtask
	task automatic rd(input string nm, input logic [7:0] ptr, input logic [7:0] e);
		logic k;
		logic [7:0] v;
		i_host.start();
		i_host.put(8'h58, k);
		i_host.put(ptr, k);
		i_host.rstart();
		i_host.put(8'h59, k);
		i_host.get(1'b0, v);
		i_host.stop();
		`CHK(nm, e, v)
	endtask
	// master acknowledges the first byte, so the pointer must move on
	task automatic rd_pair(input logic [7:0] ptr, input logic [7:0] e0, input logic [7:0] e1);
		logic k;
		logic [7:0] v0;
		logic [7:0] v1;
		i_host.start();
		i_host.put(8'h58, k);
		i_host.put(ptr, k);
		i_host.rstart();
		i_host.put(8'h59, k);
		i_host.get(1'b1, v0);
		i_host.get(1'b0, v1);
		i_host.stop();
		`CHK("burst first", e0, v0)
		`CHK("burst second", e1, v1)
	endtask
	task automatic pin(input logic v, input int n);
		@(posedge clock);
		i_host.o_pwm <= v;
		i_host.hw(n);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd("bright", 8'h00, 8'h00);
		rd("config", 8'h01, 8'h00);
		rd("fault", 8'h02, 8'h00);
		rd("ident", 8'h03, ID_VAL);
		rd("temp hi", 8'h05, 8'hB4);
		rd("temp lo", 8'h06, 8'h60);
		rd("nvm", 8'h72, 8'h80);
		rd("unmapped", 8'h10, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_bright();
		logic [8:0] cnt;
		// read-only places in the middle of the burst must not stall the pointer
		wr(8'h00, '{8'h80, 8'h05, 8'hFF, 8'hFF, 8'h5A});
		rd("bright", 8'h00, 8'h80);
		rd("config", 8'h01, 8'h05);
		rd("fault", 8'h02, 8'h00);
		`CHK("direct", 8'h5A, direct_drive)
		i_host.hw(300);
		cnt = '0;
		repeat (255) begin
			@(posedge clock);
			if (pwm_out === 1'b1) cnt++;
		end
		`CHK("duty", 9'd128, cnt)
		`CHK("bl on", 1'b1, backlight_on)
		wr(8'h01, '{8'h04});
		i_host.hw(20);
		`CHK("bl off", 1'b0, backlight_on)
		wr(8'h01, '{8'hFF});
		rd("config", 8'h01, 8'h07);
		pin(1'b0, 10);
		`CHK("pass off", 1'b0, backlight_on)
		pin(1'b1, 10);
		`CHK("pass pwm", 1'b1, pwm_out)
		$display("test brightness done");
	endtask
	task automatic t_pin();
		wr(8'h01, '{8'h01});
		pin(1'b0, 600);
		`CHK("duty off", 1'b0, backlight_on)
		wr(8'h01, '{8'h02});
		pin(1'b1, 600);
		`CHK("duty on", 1'b1, backlight_on)
		pin(1'b0, 10);
		$display("test pin source done");
	endtask
	task automatic t_fault();
		@(posedge clock);
		fault_events <= 8'h80;
		@(posedge clock);
		fault_events <= 8'h00;
		i_host.hw(3);
		`CHK("fault pin", 1'b1, fault_oe)
		`CHK("fault level", 1'b0, fault_out)
		rd("fault", 8'h02, 8'h80);
		`CHK("fault pin", 1'b0, fault_oe)
		rd("fault", 8'h02, 8'h00);
		@(posedge clock);
		fault_events <= 8'h80;
		@(posedge clock);
		fault_events <= 8'h00;
		chip_enable <= 1'b0;
		i_host.hw(10);
		`CHK("fault pin", 1'b0, fault_oe)
		chip_enable <= 1'b1;
		i_host.hw(12);
		rd("fault", 8'h02, 8'h00);
		rd("bright", 8'h00, 8'h00);
		$display("test fault done");
	endtask
	task automatic t_misc();
		`CHK("nvm cmd", 3'h0, nvm_seen)
		wr(8'h72, '{8'h05});
		`CHK("nvm cmd", 3'h5, nvm_seen)
		rd("nvm", 8'h72, 8'h80);
		rd_pair(8'h05, 8'hB4, 8'h60);
		`CHK("sda level", 1'b0, sda_out)
		$display("test misc done");
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		chip_enable = 1'b1;
		fault_events = 8'h00;
		temperature = 11'h5A3;
		nvm_idle = 1'b1;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (12) @(posedge clock);
		t_reset();
		t_bright();
		t_pin();
		t_fault();
		t_misc();
		summarize();
	end
	// a whole run needs well under half of this span
	initial begin
		repeat (90000) @(posedge clock);
		err_total++;
		summarize();
	end
endmodule
